/* logic/tcs_map.vh */
// Register map, field positions and codes of the timer status block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef TCS_MAP_VH
`define TCS_MAP_VH

// APB byte addresses
`define TCS_ADDR_W        12
`define TCS_OFF_CS0       12'h000
`define TCS_OFF_CS1       12'h004
`define TCS_OFF_IRQ_ST    12'h008
`define TCS_OFF_IRQ_MSK   12'h00c

// Control/status field positions
`define TCS_BIT_MB        3'h7
`define TCS_BIT_MA        3'h6
`define TCS_BIT_OV        3'h5
`define TCS_BIT_TRG       3'h4
`define TCS_BIT_RSV       3'h4

// Reset values
`define TCS_CS0_RST       8'h00
`define TCS_CS1_RST       8'h10
`define TCS_SEL_RST       4'h0
`define TCS_IRQ_RST       6'h00

// Output select codes
`define TCS_OS_KEEP       2'h0
`define TCS_OS_LOW        2'h1
`define TCS_OS_HIGH       2'h2
`define TCS_OS_TOGGLE     2'h3

// Counter wrap points
`define TCS_CNT_MAX       8'hff
`define TCS_CNT_MIN       8'h00

`endif

/* logic/tcs_flag.v */
// One sticky status flag cleared by read-as-one then write-zero.
// Assumes strobes are one-cycle pulses on pclk.
`timescale 1ns/1ps
module tcs_flag
(
	// Clock and reset
	input  wire pclk,
	input  wire presetn,
	// Events
	input  wire set_evt,
	input  wire rd_strobe,
	input  wire wr_strobe,
	input  wire wr_bit,
	// State
	output reg  flag_ff
);

	reg  armed_ff;
	wire clr;
	wire nxt_flag;
	wire nxt_armed;

	// Only a zero after a read of one clears; a one is ignored
	assign clr       = wr_strobe & ~wr_bit & armed_ff;
	assign nxt_flag  = set_evt | (flag_ff & ~clr);
	// Any write to the register drops the arm
	assign nxt_armed = wr_strobe ? 1'b0
		: (armed_ff | (rd_strobe & flag_ff));

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flag_ff  <= 1'b0;
			armed_ff <= 1'b0;
		end
		else
		begin
			flag_ff  <= nxt_flag;
			armed_ff <= nxt_armed;
		end
	end

endmodule // tcs_flag

/* logic/tcs_chan.v */
// Match/overflow detection and output pin control for one channel.
// Assumes counter and constants come from logic on pclk.
`timescale 1ns/1ps
`include "tcs_map.vh"
module tcs_chan
#(
	parameter CNT_W = 8
)
(
	// Clock and reset
	input  wire             pclk,
	input  wire             presetn,
	// Counter and constants
	input  wire [CNT_W-1:0] counter,
	input  wire [CNT_W-1:0] const_a,
	input  wire [CNT_W-1:0] const_b,
	// Output select, B in [3:2], A in [1:0]
	input  wire [3:0]       out_sel,
	// Events
	output wire             match_a_evt,
	output wire             match_b_evt,
	output wire             ovf_evt,
	// Pin
	output reg              timer_out_ff
);

	reg  [CNT_W-1:0] cnt_prev_ff;
	reg              eq_a_ff;
	reg              eq_b_ff;
	reg              nxt_out;
	wire             eq_a;
	wire             eq_b;

	assign eq_a = (counter == const_a);
	assign eq_b = (counter == const_b);
	// One event per arrival at the match, not per cycle spent there
	assign match_a_evt = eq_a & ~eq_a_ff;
	assign match_b_evt = eq_b & ~eq_b_ff;
	assign ovf_evt = (cnt_prev_ff == `TCS_CNT_MAX)
		& (counter == `TCS_CNT_MIN);

	function out_act;
		input [1:0] code;
		input       cur;
		begin
			case (code)
				`TCS_OS_LOW:    out_act = 1'b0;
				`TCS_OS_HIGH:   out_act = 1'b1;
				`TCS_OS_TOGGLE: out_act = ~cur;
				default:        out_act = cur;
			endcase
		end
	endfunction

	// A is applied after B, so on a joint match A acts on the value B produced
	always @*
	begin
		nxt_out = timer_out_ff;
		if (match_b_evt)
			nxt_out = out_act(out_sel[3:2], nxt_out);
		if (match_a_evt)
			nxt_out = out_act(out_sel[1:0], nxt_out);
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_prev_ff  <= `TCS_CNT_MIN;
			eq_a_ff      <= 1'b0;
			eq_b_ff      <= 1'b0;
			timer_out_ff <= 1'b0;
		end
		else
		begin
			cnt_prev_ff  <= counter;
			eq_a_ff      <= eq_a;
			eq_b_ff      <= eq_b;
			timer_out_ff <= nxt_out;
		end
	end

endmodule // tcs_chan

/* logic/tcs_top.v */
// Status flags and output control of two 8-bit timer channels, APB slave.
// Assumes counters and constant registers live elsewhere on pclk.
//
// What this block does
// - Channel 0 match B sets bit 7
// - Channel 0 match A sets bit 6
// - Channel 0 wrap to zero sets bit 5
// - Channel 1 match B sets its flag
// - Channel 1 match A sets its flag
// - Channel 1 wrap to zero sets its flag
// - Clear needs read of one, then zero
// - Writing one never sets a flag
// - Channel 0 bit 4 gates converter start on its match A
// - Channel 0 bits 3:2 steer pin on B
// - Channel 0 bits 1:0 steer pin on A
// - Channel 1 bits 3:2 steer pin on B
// - Channel 1 bits 1:0 steer pin on A
// - Channel 1 bit 4 reads one, ignores writes
`timescale 1ns/1ps
`include "tcs_map.vh"
module tcs_top
#(
	parameter CNT_W = 8
)
(
	// Clock and reset
	input  wire                   pclk,
	input  wire                   presetn,
	// APB slave
	input  wire                   psel,
	input  wire                   penable,
	input  wire                   pwrite,
	input  wire [`TCS_ADDR_W-1:0] paddr,
	input  wire [31:0]            pwdata,
	input  wire [3:0]             pstrb,
	output wire                   pready,
	output reg  [31:0]            prdata,
	output wire                   pslverr,
	// Channel 0 counter and constants
	input  wire [CNT_W-1:0]       counter_ch0,
	input  wire [CNT_W-1:0]       const_a_ch0,
	input  wire [CNT_W-1:0]       const_b_ch0,
	// Channel 1 counter and constants
	input  wire [CNT_W-1:0]       counter_ch1,
	input  wire [CNT_W-1:0]       const_a_ch1,
	input  wire [CNT_W-1:0]       const_b_ch1,
	// Pins
	output wire                   timer_out_pin_ch0,
	output wire                   timer_out_pin_ch1,
	// Converter start and interrupt
	output reg                    converter_start_req,
	output wire                   irq
);

	localparam NCH = 2;

	// Register state
	reg  [3:0]  sel_ch0_ff;
	reg  [3:0]  sel_ch1_ff;
	reg         converter_trigger_enable_ff;
	reg  [5:0]  irq_st_ff;
	reg  [5:0]  irq_msk_ff;
	reg  [31:0] rdata_ff;
	reg         addr_err_ff;
	reg  [31:0] nxt_rdata;

	// Bus phases
	wire        setup;
	wire        acc;
	wire        wr_acc;
	wire        rd_acc;
	wire        lane0;

	// Channel events, index 0 and 1
	wire [NCH-1:0] mb_evt;
	wire [NCH-1:0] ma_evt;
	wire [NCH-1:0] ov_evt;
	wire [NCH-1:0] mb_flag;
	wire [NCH-1:0] ma_flag;
	wire [NCH-1:0] ov_flag;
	wire [NCH-1:0] cs_rd;
	wire [NCH-1:0] cs_wr;
	wire [3:0]     sel_bus [0:NCH-1];
	wire [CNT_W-1:0] cnt_bus [0:NCH-1];
	wire [CNT_W-1:0] ca_bus  [0:NCH-1];
	wire [CNT_W-1:0] cb_bus  [0:NCH-1];
	wire [NCH-1:0] pin_bus;
	wire [5:0]     ev_vec;
	wire [7:0]     cs0_val;
	wire [7:0]     cs1_val;

	function hit;
		input [`TCS_ADDR_W-1:0] addr;
		input [`TCS_ADDR_W-1:0] off;
		begin
			hit = (addr == off);
		end
	endfunction

	function mapped;
		input [`TCS_ADDR_W-1:0] addr;
		begin
			mapped = hit(addr, `TCS_OFF_CS0)
				| hit(addr, `TCS_OFF_CS1)
				| hit(addr, `TCS_OFF_IRQ_ST)
				| hit(addr, `TCS_OFF_IRQ_MSK);
		end
	endfunction

	// Read data is captured in setup so the access phase needs no wait
	assign setup   = psel & ~penable;
	assign acc     = psel & penable;
	assign wr_acc  = acc & pwrite & ~addr_err_ff;
	assign rd_acc  = acc & ~pwrite & ~addr_err_ff;
	assign lane0   = pstrb[0];
	assign pready  = 1'b1;
	assign pslverr = acc & addr_err_ff;

	assign cs_wr[0] = wr_acc & lane0 & hit(paddr, `TCS_OFF_CS0);
	assign cs_wr[1] = wr_acc & lane0 & hit(paddr, `TCS_OFF_CS1);
	// The value software saw is the one latched at setup
	assign cs_rd[0] = rd_acc & hit(paddr, `TCS_OFF_CS0);
	assign cs_rd[1] = rd_acc & hit(paddr, `TCS_OFF_CS1);

	assign sel_bus[0] = sel_ch0_ff;
	assign sel_bus[1] = sel_ch1_ff;
	assign cnt_bus[0] = counter_ch0;
	assign cnt_bus[1] = counter_ch1;
	assign ca_bus[0]  = const_a_ch0;
	assign ca_bus[1]  = const_a_ch1;
	assign cb_bus[0]  = const_b_ch0;
	assign cb_bus[1]  = const_b_ch1;

	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1)
		begin : g_ch
			wire seen_mb;
			wire seen_ma;
			wire seen_ov;

			// Arm only on a one that software saw at setup; a flag
			// that rises between setup and access must not arm
			assign seen_mb = cs_rd[g] & rdata_ff[`TCS_BIT_MB];
			assign seen_ma = cs_rd[g] & rdata_ff[`TCS_BIT_MA];
			assign seen_ov = cs_rd[g] & rdata_ff[`TCS_BIT_OV];

			tcs_chan #(
				.CNT_W       (CNT_W)
			) u_chan (
				.pclk        (pclk),
				.presetn     (presetn),
				.counter     (cnt_bus[g]),
				.const_a     (ca_bus[g]),
				.const_b     (cb_bus[g]),
				.out_sel     (sel_bus[g]),
				.match_a_evt (ma_evt[g]),
				.match_b_evt (mb_evt[g]),
				.ovf_evt     (ov_evt[g]),
				.timer_out_ff(pin_bus[g])
			);

			tcs_flag u_mb (
				.pclk      (pclk),
				.presetn   (presetn),
				.set_evt   (mb_evt[g]),
				.rd_strobe (seen_mb),
				.wr_strobe (cs_wr[g]),
				.wr_bit    (pwdata[`TCS_BIT_MB]),
				.flag_ff   (mb_flag[g])
			);

			tcs_flag u_ma (
				.pclk      (pclk),
				.presetn   (presetn),
				.set_evt   (ma_evt[g]),
				.rd_strobe (seen_ma),
				.wr_strobe (cs_wr[g]),
				.wr_bit    (pwdata[`TCS_BIT_MA]),
				.flag_ff   (ma_flag[g])
			);

			tcs_flag u_ov (
				.pclk      (pclk),
				.presetn   (presetn),
				.set_evt   (ov_evt[g]),
				.rd_strobe (seen_ov),
				.wr_strobe (cs_wr[g]),
				.wr_bit    (pwdata[`TCS_BIT_OV]),
				.flag_ff   (ov_flag[g])
			);
		end
	endgenerate

	assign timer_out_pin_ch0 = pin_bus[0];
	assign timer_out_pin_ch1 = pin_bus[1];

	// Readback of the two control/status registers
	assign cs0_val = {mb_flag[0], ma_flag[0], ov_flag[0],
		converter_trigger_enable_ff, sel_ch0_ff};
	assign cs1_val = {mb_flag[1], ma_flag[1], ov_flag[1],
		1'b1, sel_ch1_ff};

	// Interrupt events: {ch1 B, A, ovf, ch0 B, A, ovf}
	assign ev_vec = {mb_evt[1], ma_evt[1], ov_evt[1],
		mb_evt[0], ma_evt[0], ov_evt[0]};
	assign irq = |(irq_st_ff & irq_msk_ff);

	always @*
	begin
		nxt_rdata = 32'h0000_0000;
		if (hit(paddr, `TCS_OFF_CS0))
			nxt_rdata[7:0] = cs0_val;
		else if (hit(paddr, `TCS_OFF_CS1))
			nxt_rdata[7:0] = cs1_val;
		else if (hit(paddr, `TCS_OFF_IRQ_ST))
			nxt_rdata[5:0] = irq_st_ff;
		else if (hit(paddr, `TCS_OFF_IRQ_MSK))
			nxt_rdata[5:0] = irq_msk_ff;
	end

	always @*
	begin
		prdata = rdata_ff;
	end

	// Bus capture
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rdata_ff    <= 32'h0000_0000;
			addr_err_ff <= 1'b0;
		end
		else if (setup)
		begin
			rdata_ff    <= pwrite ? 32'h0000_0000 : nxt_rdata;
			addr_err_ff <= ~mapped(paddr);
		end
	end

	// Control fields; reserved bit 4 of channel 1 has no storage
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sel_ch0_ff <= `TCS_SEL_RST;
			sel_ch1_ff <= `TCS_SEL_RST;
			converter_trigger_enable_ff <= 1'b0;
		end
		else
		begin
			if (cs_wr[0])
			begin
				sel_ch0_ff <= pwdata[3:0];
				converter_trigger_enable_ff <=
					pwdata[`TCS_BIT_TRG];
			end
			if (cs_wr[1])
				sel_ch1_ff <= pwdata[3:0];
		end
	end

	// Converter start is a one-cycle pulse per channel 0 match A
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			converter_start_req <= 1'b0;
		end
		else
		begin
			converter_start_req <= ma_evt[0]
				& converter_trigger_enable_ff;
		end
	end

	// Interrupt status clears on read, a new event wins over the read
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_st_ff  <= `TCS_IRQ_RST;
			irq_msk_ff <= `TCS_IRQ_RST;
		end
		else
		begin
			if (rd_acc & hit(paddr, `TCS_OFF_IRQ_ST))
			begin
				irq_st_ff <= ev_vec;
			end
			else
			begin
				irq_st_ff <= irq_st_ff | ev_vec;
			end
			if (wr_acc & lane0 & hit(paddr, `TCS_OFF_IRQ_MSK))
			begin
				irq_msk_ff <= pwdata[5:0];
			end
		end
	end

endmodule // tcs_top

/* dv/tcs_top_sva.sv */
// Checker for the timer status block, watching its ports only.
// Assumes bind from the bench top and one clock domain on pclk.
`timescale 1ns/1ps
module tcs_top_sva
#(
	parameter CNT_W = 8
)
(
	input wire             pclk,
	input wire             presetn,
	input wire             psel,
	input wire             penable,
	input wire             pwrite,
	input wire [11:0]      paddr,
	input wire             pready,
	input wire [31:0]      prdata,
	input wire             pslverr,
	input wire [CNT_W-1:0] counter_ch0,
	input wire [CNT_W-1:0] const_a_ch0,
	input wire [CNT_W-1:0] const_b_ch0,
	input wire [CNT_W-1:0] counter_ch1,
	input wire [CNT_W-1:0] const_a_ch1,
	input wire [CNT_W-1:0] const_b_ch1,
	input wire             timer_out_pin_ch0,
	input wire             timer_out_pin_ch1,
	input wire             converter_start_req
);
	wire [3:0] eq_now = {counter_ch1 == const_b_ch1, counter_ch1 == const_a_ch1,
		counter_ch0 == const_b_ch0, counter_ch0 == const_a_ch0};
	reg  [3:0] eq_ff;
	// Only a new arrival at equality is an event, as the design counts it
	wire [3:0] hit = eq_now & ~eq_ff;

	always @(posedge pclk or negedge presetn)
		if (!presetn)
			eq_ff <= 4'h0;
		else
			eq_ff <= eq_now;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	req_cause_a: assert property (converter_start_req |-> $past(hit[0]))
		else $error("converter start without match A");
	req_pulse_a: assert property (converter_start_req |=> !converter_start_req)
		else $error("converter start longer than one cycle");
	pin0_cause_a: assert property ($changed(timer_out_pin_ch0) |-> $past(|hit[1:0]))
		else $error("channel 0 pin moved without a match");
	pin1_cause_a: assert property ($changed(timer_out_pin_ch1) |-> $past(|hit[3:2]))
		else $error("channel 1 pin moved without a match");
	rsv_bit_a: assert property (psel && penable && !pwrite && paddr == 12'h004 |-> prdata[4])
		else $error("channel 1 bit 4 read as zero");
	unmapped_a: assert property (psel && penable && !pwrite && paddr > 12'h00c
		|-> pslverr && prdata == 32'h0)
		else $error("unmapped read not refused");
	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
	ready_now_a: assert property (psel && penable |-> pready)
		else $error("access phase stalled");

	cover property (hit[0] ##1 converter_start_req);
	cover property ($changed(timer_out_pin_ch1));
	cover property (pslverr);
endmodule // tcs_top_sva

/* dv/tcs_top_tb.sv */
// Self-checking bench for the timer status block over APB.
// Assumes the design files under logic/ and the checker beside it.
`timescale 1ns/1ps
module tcs_top_tb;
	localparam [7:0] ORD_A = 8'h36;
	localparam [7:0] ORD_B = 8'h39;
	reg         pclk, presetn, psel, penable, pwrite, err, pin_exp;
	reg  [11:0] paddr;
	reg  [31:0] pwdata, rd_data;
	reg  [7:0]  c0, c1, wd;
	reg  [1:0]  code;
	reg         req_seen;
	wire [31:0] prdata;
	wire        pready, pslverr, pin0, pin1, req, irq;
	integer     failures, total_checks, cycles, i;

	tcs_top tcs_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hf), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.counter_ch0(c0), .const_a_ch0(8'h10), .const_b_ch0(8'h20),
		.counter_ch1(c1), .const_a_ch1(8'h30), .const_b_ch1(8'h40),
		.timer_out_pin_ch0(pin0), .timer_out_pin_ch1(pin1),
		.converter_start_req(req), .irq(irq));

	function nx(input [1:0] c, input cur);
		nx = c[1] ? (c[0] ? ~cur : 1'h1) : (c[0] ? 1'h0 : cur);
	endfunction

	task chk(input [31:0] got, input [31:0] exp);
	begin
		total_checks = total_checks + 1;
		if (got !== exp)
		begin
			failures = failures + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask

	task xfer(input w, input [11:0] a, input [31:0] d);
	begin
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1)
			@(posedge pclk);
		rd_data = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	end
	endtask

	task rc(input [11:0] a, input [31:0] e);
	begin
		xfer(1'h0, a, 32'h0);
		chk(rd_data, e);
	end
	endtask

	// Counters sit at 01 between events, away from all constants
	task ev(input [7:0] v0, input [7:0] v1);
	begin
		@(posedge pclk);
		c0 <= v0;
		c1 <= v1;
		@(posedge pclk);
		// The start pulse stands only between these two edges
		@(negedge pclk);
		req_seen = req;
		@(posedge pclk);
		c0 <= 8'h01;
		c1 <= 8'h01;
	end
	endtask

	task end_sim;
	begin
		$display("checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask

	initial
	begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end

	always @(posedge pclk)
	begin
		cycles = cycles + 1;
		if (cycles == 3000)
		begin
			failures = failures + 1;
			end_sim;
		end
	end

	initial
	begin
		{presetn, psel, penable, pwrite, pin_exp} = 5'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		c0 = 8'h01;
		c1 = 8'h01;
		failures = 0;
		total_checks = 0;
		cycles = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		rc(12'h000, 32'h00);
		rc(12'h004, 32'h10);
		xfer(1'h1, 12'h000, 32'hff);
		rc(12'h000, 32'h1f);
		// Code order chosen so each code moves the pin where it can
		for (i = 0; i < 8; i = i + 1)
		begin
			code = (i < 4) ? ORD_A[2*i+:2] : ORD_B[2*(i-4)+:2];
			wd = (i < 4) ? {6'h04, code} : {4'h0, code, 2'h0};
			xfer(1'h1, 12'h000, {24'h0, wd});
			xfer(1'h1, 12'h004, {24'h0, wd});
			if (i < 4)
				ev(8'h10, 8'h30);
			else
				ev(8'h20, 8'h40);
			pin_exp = nx(code, pin_exp);
			chk(pin0, pin_exp);
			chk(pin1, pin_exp);
			chk(req_seen, i < 4);
		end
		ev(8'h10, 8'h30);
		chk(req_seen, 0);
		chk(pin0, pin_exp);
		rc(12'h000, 32'hc0);
		xfer(1'h1, 12'h000, 32'h0);
		rc(12'h000, 32'h00);
		rc(12'h004, 32'hd0);
		@(posedge pclk);
		c0 <= 8'hff;
		c1 <= 8'hff;
		ev(8'h00, 8'h00);
		rc(12'h000, 32'h20);
		rc(12'h004, 32'hf0);
		chk(irq, 0);
		xfer(1'h1, 12'h00c, 32'h3f);
		#1 chk(irq, 1);
		rc(12'h008, 32'h3f);
		#1 chk(irq, 0);
		rc(12'h008, 32'h00);
		rc(12'h00c, 32'h3f);
		xfer(1'h1, 12'h010, 32'hff);
		chk(err, 1);
		rc(12'h010, 32'h0);
		chk(err, 1);
		end_sim;
	end
endmodule // tcs_top_tb

bind tcs_top tcs_top_sva #(.CNT_W(CNT_W)) tcs_top_sva_inst (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pready, .prdata, .pslverr,
	.counter_ch0, .const_a_ch0, .const_b_ch0, .counter_ch1, .const_a_ch1,
	.const_b_ch1, .timer_out_pin_ch0, .timer_out_pin_ch1, .converter_start_req);
